// *** inc/sram_defs.svh ***
// Timing and geometry constants for the asynchronous static memory controller
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH

`define SRC_ADDR_W        14
`define SRC_DATA_W        4
`define SRC_CLK_NS        10
// Slowest grade figures, in ns
`define SRC_READ_CYCLE_NS 25
`define SRC_ACCESS_NS     20
`define SRC_SEL_WR_NS     20
`define SRC_DATA_SETUP_NS 10
`define SRC_DESEL_RET_NS  0
// Least times round up to whole cycles, none below one
`define SRC_CYC_UP(ns)    (((ns) + `SRC_CLK_NS - 1) / `SRC_CLK_NS < 1 ? 1 : \
                           ((ns) + `SRC_CLK_NS - 1) / `SRC_CLK_NS)
`define SRC_READ_CYC      `SRC_CYC_UP(`SRC_READ_CYCLE_NS)
`define SRC_ACCESS_CYC    `SRC_CYC_UP(`SRC_ACCESS_NS)
`define SRC_WRITE_CYC     `SRC_CYC_UP(`SRC_SEL_WR_NS)
`define SRC_RET_CYC       `SRC_CYC_UP(`SRC_DESEL_RET_NS)
`define SRC_CNT_W         4
// Read data lands one edge after the access time, then crosses two sync stages
`define SRC_SYNC_LAT      3

`endif

// *** inc/src_pkg.sv ***
// Types shared by the static memory controller files
package src_pkg;
    typedef struct packed {
        logic        wr;
        logic [13:0] addr;
        logic [3:0]  wdata;
    } src_req_s;

    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic oe_n;
    } src_ctl_s;

    typedef enum logic [5:0] {
        SRC_IDLE  = 6'b000001,
        SRC_SETUP = 6'b000010,
        SRC_READ  = 6'b000100,
        SRC_WRITE = 6'b001000,
        SRC_END   = 6'b010000,
        SRC_RET   = 6'b100000
    } src_state_e;
endpackage

// *** logic/src_sync.sv ***
// Two flip-flop synchroniser for the data pins read back from the memory
`timescale 1ns/1ps
`include "sram_defs.svh"
module src_sync
    import src_pkg::*;
#(
    parameter int W = `SRC_DATA_W
)
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            meta_reg <= '0;
            q_o      <= '0;
        end
        else
        begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule

// *** logic/src_ctrl.sv ***
// Host controller for a 16K x 4 asynchronous static memory
// What this block does
// - Writes happen while select and write strobe are both low; data driven then.
// - Reads hold write strobe high, select and output drive low.
// - Write period runs from the later falling to the earlier rising strobe.
// - Address is valid no later than select going active.
// - Deselect before retention; wait one read cycle after retention ends.
// - Select stays active at least the grade minimum before write end.
`timescale 1ns/1ps
`include "sram_defs.svh"
module src_ctrl
    import src_pkg::*;
#(
    parameter int AW       = `SRC_ADDR_W,
    parameter int DW       = `SRC_DATA_W,
    parameter int READ_CYC = `SRC_READ_CYC,
    parameter int ACC_CYC  = `SRC_ACCESS_CYC,
    parameter int WR_CYC   = `SRC_WRITE_CYC
)
(
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    // User request
    input  wire logic          req_valid_i,
    input  wire src_req_s      req_i,
    output logic               req_ready_o,
    output logic               rd_valid_o,
    output logic      [DW-1:0] rd_data_o,
    // Retention control
    input  wire logic          retain_i,
    output logic               retain_ok_o,
    // Memory pins
    output logic      [AW-1:0] mem_addr_o,
    output logic               mem_cs_n_o,
    output logic               mem_we_n_o,
    output logic               mem_oe_n_o,
    input  wire logic [DW-1:0] mem_dq_i,
    output logic      [DW-1:0] mem_dq_o,
    output logic               mem_dq_oe_n_o
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    src_state_e    state_reg;
    logic [3:0]    cnt_reg;
    logic          wr_reg;
    logic [DW-1:0] dq_sync;

    src_sync #(.W(DW)) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (mem_dq_i),
        .q_o     (dq_sync)
    );

    // Data valid exactly at the access edge would race the first sync stage,
    // so select is held one edge past it plus the two sync stages
    localparam logic [3:0] RD_HOLD = 4'(ACC_CYC + `SRC_SYNC_LAT);
    localparam logic [3:0] WR_HOLD = 4'(WR_CYC);
    localparam logic [3:0] RC_HOLD = 4'(READ_CYC);

    function automatic logic cnt_done(input logic [3:0] c, input logic [3:0] lim);
        cnt_done = (c + 4'h1 >= lim);
    endfunction

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            state_reg <= SRC_IDLE;
            cnt_reg   <= 4'h0;
            wr_reg    <= 1'b0;
        end
        else
        begin
            case (state_reg)
                SRC_IDLE:
                begin
                    cnt_reg <= 4'h0;
                    if (retain_i)
                        state_reg <= SRC_RET;
                    else if (req_valid_i)
                    begin
                        wr_reg    <= req_i.wr;
                        state_reg <= SRC_SETUP;
                    end
                end
                SRC_SETUP:
                    state_reg <= wr_reg ? SRC_WRITE : SRC_READ;
                SRC_READ:
                begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_done(cnt_reg, RD_HOLD))
                    begin
                        cnt_reg   <= 4'h0;
                        state_reg <= SRC_END;
                    end
                end
                SRC_WRITE:
                begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_done(cnt_reg, WR_HOLD))
                    begin
                        cnt_reg   <= 4'h0;
                        state_reg <= SRC_END;
                    end
                end
                SRC_END:
                    // Deselected gap keeps the read cycle minimum between accesses
                    state_reg <= SRC_IDLE;
                SRC_RET:
                begin
                    if (retain_i)
                        cnt_reg <= 4'h0;
                    else if (cnt_done(cnt_reg, RC_HOLD))
                        state_reg <= SRC_IDLE;
                    else
                        cnt_reg <= cnt_reg + 4'h1;
                end
                default:
                    state_reg <= SRC_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            mem_cs_n_o <= 1'b1;
            mem_we_n_o <= 1'b1;
            mem_oe_n_o <= 1'b1;
        end
        else
        begin
            // Select and strobes rise together; select-controlled write end
            mem_cs_n_o <= !(state_reg == SRC_SETUP ||
                            (state_reg == SRC_READ && !cnt_done(cnt_reg, RD_HOLD)) ||
                            (state_reg == SRC_WRITE && !cnt_done(cnt_reg, WR_HOLD)));
            mem_we_n_o <= !((state_reg == SRC_SETUP && wr_reg) ||
                            (state_reg == SRC_WRITE && !cnt_done(cnt_reg, WR_HOLD)));
            mem_oe_n_o <= !((state_reg == SRC_SETUP && !wr_reg) ||
                            (state_reg == SRC_READ && !cnt_done(cnt_reg, RD_HOLD)));
        end
    end

    // Address and write data are latched once per access and held through it
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            mem_addr_o    <= '0;
            mem_dq_o      <= '0;
            mem_dq_oe_n_o <= 1'b1;
        end
        else
        begin
            if (state_reg == SRC_IDLE && req_valid_i && !retain_i)
            begin
                mem_addr_o <= req_i.addr[AW-1:0];
                mem_dq_o   <= req_i.wdata[DW-1:0];
            end
            // Drive data one cycle beyond strobe release for hold margin
            mem_dq_oe_n_o <= !(state_reg == SRC_SETUP ? wr_reg :
                               state_reg == SRC_WRITE);
        end
    end

    // ----------------------------------------
    // User side
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            req_ready_o <= 1'b0;
            rd_valid_o  <= 1'b0;
            rd_data_o   <= '0;
            retain_ok_o <= 1'b0;
        end
        else
        begin
            req_ready_o <= (state_reg == SRC_END) ||
                           (state_reg == SRC_IDLE && !(req_valid_i || retain_i));
            rd_valid_o  <= state_reg == SRC_READ && cnt_done(cnt_reg, RD_HOLD);
            if (state_reg == SRC_READ && cnt_done(cnt_reg, RD_HOLD))
                rd_data_o <= dq_sync;
            retain_ok_o <= state_reg == SRC_RET && retain_i && mem_cs_n_o;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_no_we_in_read;
        @(posedge clk_i) disable iff (!rst_b_i)
        !mem_oe_n_o |-> mem_we_n_o;
    endproperty
    a_no_we_in_read: assert property (p_no_we_in_read)
        else $error("write strobe low during read");

    property p_we_needs_cs;
        @(posedge clk_i) disable iff (!rst_b_i)
        !mem_we_n_o |-> !mem_cs_n_o && !mem_dq_oe_n_o;
    endproperty
    a_we_needs_cs: assert property (p_we_needs_cs)
        else $error("write strobe without select or data");

    property p_addr_stable;
        @(posedge clk_i) disable iff (!rst_b_i)
        !mem_cs_n_o && $past(!mem_cs_n_o) |-> $stable(mem_addr_o);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("address moved during access");

    property p_wr_len;
        @(posedge clk_i) disable iff (!rst_b_i)
        $fell(mem_we_n_o) |-> !mem_we_n_o [*2];
    endproperty
    a_wr_len: assert property (p_wr_len)
        else $error("write period too short");

    property p_rd_len;
        @(posedge clk_i) disable iff (!rst_b_i)
        $fell(mem_oe_n_o) |-> !mem_cs_n_o [*5];
    endproperty
    a_rd_len: assert property (p_rd_len)
        else $error("read select too short");

    property p_rd_done;
        @(posedge clk_i) disable iff (!rst_b_i)
        $fell(mem_oe_n_o) |-> ##[1:12] rd_valid_o;
    endproperty
    a_rd_done: assert property (p_rd_done)
        else $error("read never completed");

    property p_standby;
        @(posedge clk_i) disable iff (!rst_b_i)
        mem_cs_n_o |-> mem_we_n_o && mem_oe_n_o;
    endproperty
    a_standby: assert property (p_standby)
        else $error("strobe active while deselected");

    property p_ret_recover;
        @(posedge clk_i) disable iff (!rst_b_i)
        $fell(retain_ok_o) |-> mem_cs_n_o [*3];
    endproperty
    a_ret_recover: assert property (p_ret_recover)
        else $error("access too soon after retention");
endmodule

// *** verification/src_mem_model.sv ***
// Behavioural model of the 16K x 4 asynchronous static memory
`timescale 1ns/1ps
module src_mem_model
(
    // Memory pins
    input  wire logic [13:0] addr_i,
    input  wire logic        cs_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [3:0]  dq_i,
    output logic      [3:0]  dq_o,
    output logic             drive_o,
    // Answer speed
    input  wire logic        slow_i
);
    logic [3:0] mem [16384];
    logic       sel;
    logic       fast_ok;
    logic       slow_ok;
    logic [3:0] held;

    assign sel = !cs_n_i && !oe_n_i && we_n_i;
    // Release lags too, so old data outlives the select or output enable change
    assign #3 fast_ok = sel;
    assign #20 slow_ok = sel;
    assign drive_o = slow_i ? slow_ok : fast_ok;
    // Either strobe may end the write; the word is taken as it ends
    always @(posedge (cs_n_i | we_n_i)) mem[addr_i] = dq_i;
    always_latch if (drive_o) held = mem[addr_i];
    // Released pins show the inverse so a stale value cannot pass
    assign dq_o = drive_o ? held : ~held;
endmodule

// *** verification/tb_src_ctrl.sv ***
// Self-checking bench for the static memory controller
`timescale 1ns/1ps
module tb_src_ctrl
    import src_pkg::*;
;
    logic        clk_i, rst_b_i, req_valid_i, retain_i, slow, drive, pcs;
    logic        req_ready_o, rd_valid_o, retain_ok_o, mem_dq_oe_n_o;
    logic        mem_cs_n_o, mem_we_n_o, mem_oe_n_o;
    src_req_s    req_i;
    logic [3:0]  rd_data_o, mem_dq_o, mem_dq_i, mdq;
    logic [13:0] mem_addr_o, last_a, al [10], a_q [$];
    logic [3:0]  sh [16384], exp_d [$];
    int          fail_count, comparisons, cyc, seed, wcnt, due_q [$];

    // ----------------------------------------
    // Design, memory and shared data wire
    // ----------------------------------------
    src_ctrl dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o),
        .rd_data_o(rd_data_o), .retain_i(retain_i), .retain_ok_o(retain_ok_o),
        .mem_addr_o(mem_addr_o), .mem_cs_n_o(mem_cs_n_o), .mem_we_n_o(mem_we_n_o),
        .mem_oe_n_o(mem_oe_n_o), .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o),
        .mem_dq_oe_n_o(mem_dq_oe_n_o));
    src_mem_model mem (.addr_i(mem_addr_o), .cs_n_i(mem_cs_n_o), .we_n_i(mem_we_n_o),
        .oe_n_i(mem_oe_n_o), .dq_i(mem_dq_i), .dq_o(mdq), .drive_o(drive),
        .slow_i(slow));
    assign mem_dq_i = !mem_dq_oe_n_o ? mem_dq_o : mdq;

    initial forever #5 clk_i = ~clk_i;

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Mode 0 waits for a fresh select fall, not a previous access still selected;
    // mode 1 waits for retention granted
    task automatic wait_on(input int mode);
        logic hi;
        hi = 1'b0;
        for (int n = 0; n < 40; n++)
        begin
            @(posedge clk_i);
            #1;
            if (mode == 0 && mem_cs_n_o === 1'b1)
                hi = 1'b1;
            else if (mode == 0 ? hi : retain_ok_o === 1'b1)
                return;
        end
        fail_count++;
        test_done();
    endtask

    // For a read, d is the word expected back
    task automatic access(input logic wr, input logic [13:0] a, input logic [3:0] d);
        @(negedge clk_i);
        req_valid_i = 1'b1;
        req_i = '{wr, a, d};
        a_q.push_back(a);
        if (!wr)
            exp_d.push_back(d);
        wait_on(0);
        @(negedge clk_i);
        req_valid_i = 1'b0;
    endtask

    // ----------------------------------------
    // Pin watcher and result compare
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        cyc++;
        if (rst_b_i)
        begin
            if (!mem_oe_n_o) check("strobe in read", mem_we_n_o, 1'b1);
            check("pin contention", drive & ~mem_dq_oe_n_o, 1'b0);
            if (!mem_cs_n_o && !mem_we_n_o) wcnt++;
            if (pcs && !mem_cs_n_o)
            begin
                last_a = a_q.pop_front();
                check("address at select", mem_addr_o, last_a);
                if (mem_we_n_o) due_q.push_back(cyc + 5);
            end
            if (!pcs && !mem_cs_n_o) check("address held", mem_addr_o, last_a);
            if (!pcs && mem_cs_n_o && wcnt > 0)
            begin
                check("write select cycles", wcnt >= 2, 1'b1);
                wcnt = 0;
            end
            if (rd_valid_o && exp_d.size() == 0) check("read count", 1'b1, 1'b0);
            else if (rd_valid_o)
            begin
                check("read data", rd_data_o, exp_d.pop_front());
                check("read latency", cyc, due_q.pop_front());
            end
        end
        pcs = mem_cs_n_o;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        seed = 23918;
        clk_i = 1'b0;
        rst_b_i = 1'b0;
        req_valid_i = 1'b0;
        retain_i = 1'b0;
        slow = 1'b0;
        pcs = 1'b1;
        req_i = '0;
        repeat (20) @(negedge clk_i);
        rst_b_i = 1'b1;
        check("reset pins", {mem_cs_n_o, mem_we_n_o, mem_oe_n_o, mem_dq_oe_n_o,
            req_ready_o, rd_valid_o, retain_ok_o}, 16'h0078);
        $display("reset test done");
        for (int i = 0; i < 10; i++)
        begin
            al[i] = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3fff : 14'($random(seed));
            sh[al[i]] = 4'($random(seed));
            access(1'b1, al[i], sh[al[i]]);
        end
        for (int i = 0; i < 10; i++)
        begin
            // Speed changes only with the memory idle
            if (i == 5)
            begin
                repeat (8) @(negedge clk_i);
                slow = 1'b1;
            end
            access(1'b0, al[i], sh[al[i]]);
        end
        $display("write and read test done");
        sh[14'h3fff] = ~sh[14'h3fff];
        access(1'b1, 14'h3fff, sh[14'h3fff]);
        @(negedge clk_i);
        retain_i = 1'b1;
        wait_on(1);
        @(negedge clk_i);
        req_valid_i = 1'b1;
        req_i = '{1'b0, 14'h3fff, 4'h0};
        a_q.push_back(14'h3fff);
        exp_d.push_back(sh[14'h3fff]);
        repeat (4) @(negedge clk_i) check("select in retention", mem_cs_n_o, 1'b1);
        retain_i = 1'b0;
        repeat (2) @(negedge clk_i) check("select in recovery", mem_cs_n_o, 1'b1);
        wait_on(0);
        @(negedge clk_i);
        req_valid_i = 1'b0;
        repeat (12) @(negedge clk_i);
        check("reads answered", exp_d.size(), 16'h0000);
        check("ready when idle", req_ready_o, 1'b1);
        $display("retention test done");
        test_done();
    end
endmodule
